// ### logic/vih_pkg.sv
// shared constants for the vectored interrupt handler
package vih_pkg;
   localparam int unsigned NumSrc = 12;
   localparam int unsigned HalfSrc = 6;
   // register byte offsets on the wishbone slave
   localparam logic [4:0] OffIrqEnable = 5'h00;
   localparam logic [4:0] OffExtEnable = 5'h04;
   localparam logic [4:0] OffPrioSel = 5'h08;
   localparam logic [4:0] OffExtPrioSel = 5'h0C;
   localparam logic [4:0] OffPending = 5'h10;
   localparam logic [4:0] OffStatus = 5'h14;
   // field positions
   localparam int unsigned GlobalEnBit = 7;
   localparam int unsigned StatSrcLsb = 8;
   localparam int unsigned StatActBit = 12;
   // reset values
   localparam logic [7:0] RstEnable = 8'h00;
   localparam logic [5:0] RstPrio = 6'h00;
   localparam logic [11:0] RstPending = 12'h000;
   // vector layout: first vector above the reset vector, fixed stride
   localparam logic [15:0] VecBase = 16'h0003;
   localparam logic [15:0] VecStride = 16'h0008;
   // sources whose flag hardware clears on vectoring
   localparam logic [11:0] HwClearMask = 12'h00F;
   typedef enum logic {VIH_RUN, VIH_HOLD} vih_state_t;
endpackage : vih_pkg

// ### logic/vih_arb_if.sv
// arbitration request and result between handler and arbiter
`timescale 1ns/1ps
`default_nettype none
interface vih_arb_if;
   logic [11:0] active;
   logic [11:0] highSel;
   logic        valid;
   logic [3:0]  src;
   logic        high;
   modport arbiter (input active, input highSel,
                    output valid, output src, output high);
   modport client (output active, output highSel,
                   input valid, input src, input high);
endinterface : vih_arb_if
`default_nettype wire

// ### logic/vih_arbiter.sv
// two-level fixed-order priority arbiter
`timescale 1ns/1ps
`default_nettype none
module vih_arbiter #(
   parameter int unsigned NUM_SRC = vih_pkg::NumSrc
) (
   vih_arb_if.arbiter arb
);
   logic [11:0] hiReq;
   logic [11:0] loReq;

   always_comb begin
      hiReq = arb.active & arb.highSel;
      loReq = arb.active & ~arb.highSel;
      arb.valid = |arb.active;
      arb.high = |hiReq;
      arb.src = 4'h0;
      // high level wins, lowest index first within a level
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (arb.high ? hiReq[i] : loReq[i]) begin
            arb.src = 4'(i);
         end
      end
   end
endmodule : vih_arbiter
`default_nettype wire

// ### logic/vih_top.sv
// vectored interrupt handler with wishbone register access
// Summary of operation
// R01 - twelve sources, two priority levels each
// R02 - source condition sets its pending flag
// R03 - flags set even when source disabled
// R04 - enabled set flag requests, disabled ignored
// R05 - each source has own enable bit
// R06 - source enables count only under global enable
// R07 - global enable zero blocks every source
// R08 - after instruction ends, call source vector
// R09 - return resumes at next skipped instruction
// R10 - clear then single-cycle op may still vector
// R11 - clear then multi-cycle op never vectors
// R12 - only some flags cleared on vectoring
// R13 - flag still set re-enters after one instruction
// R14 - software flag set acts as request
// R15 - high preempts low, high never preempted
// R16 - higher level wins, then lowest order
// R17 - sample every clock, three cycle minimum
// R18 - equal or lower waits return plus one
// R19 - vectors eight bytes apart from three
// R20 - in-service tracked per priority level
`timescale 1ns/1ps
`default_nettype none
module vih_top (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [11:0] srcEvent,
   input  wire logic        instrDone,
   input  wire logic        instrMulti,
   input  wire logic        instrReti,
   output logic             vecCall,
   output logic      [15:0] vecAddr,
   output logic      [1:0]  inService
);
   vih_arb_if arb ();

   logic [7:0]       irqEnable_q, irqEnable_d;
   logic [5:0]       extEnable_q, extEnable_d;
   logic [5:0]       prioSel_q, prioSel_d;
   logic [5:0]       extPrioSel_q, extPrioSel_d;
   logic [11:0]      pending_q, pending_d;
   logic             grace_q, grace_d;
   vih_pkg::vih_state_t state_q, state_d;
   logic [1:0]       isv_q, isv_d;
   logic             reqValid_q, reqValid_d;
   logic [3:0]       reqSrc_q, reqSrc_d;
   logic             reqHigh_q, reqHigh_d;
   logic             vecCall_q, vecCall_d;
   logic [15:0]      vecAddr_q, vecAddr_d;
   logic [3:0]       lastSrc_q, lastSrc_d;
   logic             ack_q, ack_d;
   logic [31:0]      rdat_q, rdat_d;
   logic             wrEn;
   logic             globalEn;
   logic [11:0]      srcEnable;
   logic             takeNow;
   logic             preemptOk;

   function automatic logic [15:0] vecOf(input logic [3:0] src);
      vecOf = vih_pkg::VecBase + 16'(src) * vih_pkg::VecStride; // R19
   endfunction : vecOf

   function automatic logic hit(input logic [4:0] adr,
                                input logic [4:0] off);
      hit = (adr == off);
   endfunction : hit

   assign globalEn  = irqEnable_q[vih_pkg::GlobalEnBit];
   // per-source enables from both enable registers, not gated by the global bit
   assign srcEnable = {extEnable_q, irqEnable_q[5:0]}; // R05
   assign wrEn = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

   // a flag of a disabled source never reaches the arbiter
   assign arb.active  = pending_q & srcEnable &
                        {12{globalEn | grace_q}}; // R04 R06 R07
   assign arb.highSel = {extPrioSel_q, prioSel_q}; // R01

   vih_arbiter #(
      .NUM_SRC (vih_pkg::NumSrc)
   ) u_arb (
      .arb (arb)
   );

   // detect stage: request re-sampled every clock
   always_comb begin
      reqValid_d = arb.valid; // R17
      reqSrc_d   = arb.src; // R16
      reqHigh_d  = arb.high; // R16
   end

   // nesting: low service may be preempted only by high, high by nothing
   always_comb begin
      unique case (isv_q)
         2'b00:   preemptOk = 1'b1;
         2'b01:   preemptOk = reqHigh_q; // R15 R18
         default: preemptOk = 1'b0; // R15
      endcase
   end

   // grace: a request after clearing the global bit still counts across
   // a following single-cycle instruction, never a multi-cycle one;
   // a return boundary never vectors, the instruction after it may
   assign takeNow = instrDone & ~instrReti & reqValid_q & preemptOk &
                    (globalEn | (grace_q & ~instrMulti)); // R08 R10 R11 R13

   always_comb begin
      grace_d = grace_q;
      if (instrDone) begin
         grace_d = 1'b0;
      end
      if (wrEn && hit(wb_adr_i, vih_pkg::OffIrqEnable) &&
          globalEn && !wb_dat_i[vih_pkg::GlobalEnBit]) begin
         grace_d = 1'b1; // R10
      end
   end

   // marks the one instruction that runs after a return
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         vih_pkg::VIH_RUN: begin
            if (instrDone && instrReti) begin
               state_d = vih_pkg::VIH_HOLD; // R13 R18
            end
         end
         vih_pkg::VIH_HOLD: begin
            if (instrDone && !instrReti) begin
               state_d = vih_pkg::VIH_RUN; // R09 R13
            end
         end
      endcase
   end

   // in-service per level; return retires the highest active level
   always_comb begin
      isv_d = isv_q;
      if (instrDone && instrReti) begin
         if (isv_q[1]) begin
            isv_d[1] = 1'b0; // R20
         end else begin
            isv_d[0] = 1'b0; // R20
         end
      end
      if (takeNow) begin
         if (reqHigh_q) begin
            isv_d[1] = 1'b1; // R20
         end else begin
            isv_d[0] = 1'b1; // R20
         end
      end
   end

   always_comb begin
      vecCall_d = takeNow; // R08 R17
      vecAddr_d = vecAddr_q;
      lastSrc_d = lastSrc_q;
      if (takeNow) begin
         vecAddr_d = vecOf(reqSrc_q); // R19
         lastSrc_d = reqSrc_q;
      end
   end

   // pending flags: software write replaces, hardware set wins over clear
   always_comb begin
      pending_d = pending_q;
      if (wrEn && hit(wb_adr_i, vih_pkg::OffPending)) begin
         pending_d = wb_dat_i[11:0]; // R14
      end
      if (takeNow) begin
         pending_d = pending_d &
                     ~(vih_pkg::HwClearMask & (12'h001 << reqSrc_q)); // R12
      end
      pending_d = pending_d | srcEvent; // R02 R03
   end

   // register writes take effect on the edge that sees ack high
   always_comb begin
      irqEnable_d  = irqEnable_q;
      extEnable_d  = extEnable_q;
      prioSel_d    = prioSel_q;
      extPrioSel_d = extPrioSel_q;
      if (wrEn) begin
         if (hit(wb_adr_i, vih_pkg::OffIrqEnable)) begin
            irqEnable_d = {wb_dat_i[7], 1'b0, wb_dat_i[5:0]}; // R05 R07
         end
         if (hit(wb_adr_i, vih_pkg::OffExtEnable)) begin
            extEnable_d = wb_dat_i[5:0]; // R05
         end
         if (hit(wb_adr_i, vih_pkg::OffPrioSel)) begin
            prioSel_d = wb_dat_i[5:0]; // R01
         end
         if (hit(wb_adr_i, vih_pkg::OffExtPrioSel)) begin
            extPrioSel_d = wb_dat_i[5:0]; // R01
         end
      end
   end

   // single-wait-state slave; unmapped reads return zero
   always_comb begin
      ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
      rdat_d = rdat_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) begin
         unique case (wb_adr_i)
            vih_pkg::OffIrqEnable:  rdat_d = {24'h000000, irqEnable_q};
            vih_pkg::OffExtEnable:  rdat_d = {26'h0000000, extEnable_q};
            vih_pkg::OffPrioSel:    rdat_d = {26'h0000000, prioSel_q};
            vih_pkg::OffExtPrioSel: rdat_d = {26'h0000000, extPrioSel_q};
            vih_pkg::OffPending:    rdat_d = {20'h00000, pending_q};
            vih_pkg::OffStatus:     rdat_d = {19'h00000, reqValid_q,
                                              lastSrc_q, 6'h00, isv_q};
            default:                rdat_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irqEnable_q  <= vih_pkg::RstEnable;
         extEnable_q  <= vih_pkg::RstPrio;
         prioSel_q    <= vih_pkg::RstPrio;
         extPrioSel_q <= vih_pkg::RstPrio;
         pending_q    <= vih_pkg::RstPending;
         grace_q      <= 1'b0;
         state_q      <= vih_pkg::VIH_RUN;
         isv_q        <= 2'b00;
         reqValid_q   <= 1'b0;
         reqSrc_q     <= 4'h0;
         reqHigh_q    <= 1'b0;
         vecCall_q    <= 1'b0;
         vecAddr_q    <= 16'h0000;
         lastSrc_q    <= 4'h0;
         ack_q        <= 1'b0;
         rdat_q       <= 32'h00000000;
      end else begin
         irqEnable_q  <= irqEnable_d;
         extEnable_q  <= extEnable_d;
         prioSel_q    <= prioSel_d;
         extPrioSel_q <= extPrioSel_d;
         pending_q    <= pending_d;
         grace_q      <= grace_d;
         state_q      <= state_d;
         isv_q        <= isv_d;
         reqValid_q   <= reqValid_d;
         reqSrc_q     <= reqSrc_d;
         reqHigh_q    <= reqHigh_d;
         vecCall_q    <= vecCall_d;
         vecAddr_q    <= vecAddr_d;
         lastSrc_q    <= lastSrc_d;
         ack_q        <= ack_d;
         rdat_q       <= rdat_d;
      end
   end

   assign wb_dat_o  = rdat_q;
   assign wb_ack_o  = ack_q;
   assign vecCall   = vecCall_q;
   assign vecAddr   = vecAddr_q;
   assign inService = isv_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence retiDone;
      instrDone && instrReti;
   endsequence

   sequence holdDone;
      (state_q == vih_pkg::VIH_HOLD) && instrDone && !instrReti;
   endsequence

   AST_CALL_AFTER_DONE: assert property ( // R08
      vecCall |-> $past(instrDone) && $past(reqValid_q))
      else $error("vector call without a finished instruction");

   AST_VEC_ADDR: assert property ( // R19
      vecCall |-> vecAddr == 16'h0003 + 16'(8 * $past(reqSrc_q)))
      else $error("vector address does not match source");

   AST_GLOBAL_BLOCK: assert property ( // R07
      !globalEn && !grace_q |=> !vecCall)
      else $error("vectored while globally disabled");

   AST_MULTI_BLOCK: assert property ( // R11
      !globalEn && instrDone && instrMulti |=> !vecCall)
      else $error("vectored after clear and multi-cycle op");

   AST_FLAG_SET: assert property ( // R02
      (srcEvent != 12'h000) |=> ((pending_q & $past(srcEvent))
                                 == $past(srcEvent)))
      else $error("source event did not set its flag");

   AST_HIGH_NOT_PREEMPTED: assert property ( // R15
      isv_q[1] |=> !vecCall)
      else $error("high level service was preempted");

   AST_HOLD_AFTER_RETURN: assert property ( // R13
      retiDone |=> !vecCall ##0 (state_q == vih_pkg::VIH_HOLD))
      else $error("no hold instruction after return");

   AST_REENTRY_NEXT: assert property ( // R13
      holdDone ##0 (reqValid_q && preemptOk && globalEn) |=> vecCall)
      else $error("no re-entry after the instruction following return");

   AST_ISV_LEVEL: assert property ( // R20
      takeNow |=> ($past(reqHigh_q) ? isv_q[1] : isv_q[0]))
      else $error("in-service level not recorded");

   AST_HW_CLEAR: assert property ( // R12
      takeNow && !reqSrc_q[3] && !reqSrc_q[2] &&
      !srcEvent[reqSrc_q] && !wrEn |=> !pending_q[$past(reqSrc_q)])
      else $error("hardware-cleared flag stayed set");

   AST_WB_ACK: assert property (
      wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q)
      else $error("wishbone ack not a single pulse");
endmodule : vih_top
`default_nettype wire

// ### verification/vih_core_model.sv
// core sequencer model: paced instruction completions
`timescale 1ns/1ps
`default_nettype none
module vih_core_model (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic run,
   input  wire logic multi,
   input  wire logic retiNext,
   input  wire logic vecCall,
   output logic      instrDone,
   output logic      instrMulti,
   output logic      instrReti
);
   logic [1:0] cnt;
   logic       retiQ;
   // qualifiers toggle between completions so a design may not lean on them
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt        <= 2'h0;
         retiQ      <= 1'b0;
         instrDone  <= 1'b0;
         instrMulti <= 1'b0;
         instrReti  <= 1'b0;
      end else begin
         instrDone <= 1'b0;
         if (retiNext) retiQ <= 1'b1;
         if (vecCall) cnt <= 2'h0;
         else if (run) cnt <= cnt + 2'h1;
         if (run && !vecCall && cnt == 2'h3) begin
            instrDone  <= 1'b1;
            instrMulti <= multi;
            instrReti  <= retiQ | retiNext;
            retiQ      <= 1'b0;
         end else begin
            instrMulti <= ~instrMulti;
            instrReti  <= ~instrReti;
         end
      end
   end
endmodule : vih_core_model
`default_nettype wire

// ### verification/vectored_interrupt_handler_tb_top.sv
// self-checking bench for the vectored interrupt handler
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_handler_tb_top;
   typedef struct packed {
      logic [11:0] evt;
      logic [11:0] prio;
      logic [15:0] vec;
      logic [11:0] pend;
   } vih_row_t;
   logic        sys_clk, reset_n, wbCyc, wbStb, wbWe, wbAck, vecCall;
   logic        run, multi, retiNext, instrDone, instrMulti, instrReti;
   logic [4:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDat, wbDatO, rd;
   logic [11:0] srcEvent;
   logic [15:0] vecAddr;
   logic [1:0]  inService, e;
   int          fails, total_checks, n;
   vih_row_t    rows [14];

   vih_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
      .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .srcEvent(srcEvent), .instrDone(instrDone), .instrMulti(instrMulti),
      .instrReti(instrReti), .vecCall(vecCall), .vecAddr(vecAddr),
      .inService(inService));
   vih_core_model core_u (.sys_clk(sys_clk), .reset_n(reset_n), .run(run),
      .multi(multi), .retiNext(retiNext), .vecCall(vecCall),
      .instrDone(instrDone), .instrMulti(instrMulti), .instrReti(instrReti));

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] s, x);
      total_checks++;
      if (s !== x) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask : chk

   // read data is taken in the ack cycle, the request drops after its edge
   task automatic wb(input logic w, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      int k;
      k = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe  <= w;
      wbAdr <= a;
      wbDat <= d;
      wbSel <= s;
      do begin
         @(posedge sys_clk);
         k++;
      end while (wbAck !== 1'b1 && k < 20);
      if (wbAck !== 1'b1) begin
         fails++;
         conclude();
      end
      // pre-edge values: ack and data as the design showed them at this edge
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge sys_clk);
   endtask : wb

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask : wr

   task automatic rdchk(input logic [4:0] a, input logic [31:0] x);
      wb(1'b0, a, 32'h0, 4'hF);
      chk("reg", rd, x);
   endtask : rdchk

   task automatic evt(input logic [11:0] m);
      srcEvent <= m;
      @(posedge sys_clk);
      srcEvent <= 12'h000;
   endtask : evt

   task automatic waitCall(input logic [15:0] v);
      int k;
      k = 0;
      do begin
         @(negedge sys_clk);
         k++;
      end while (vecCall !== 1'b1 && k < 60);
      chk("call", {31'h0, vecCall}, 32'h1);
      if (vecCall !== 1'b1) conclude();
      chk("vec", {16'h0, vecAddr}, {16'h0, v});
      @(posedge sys_clk);
   endtask : waitCall

   task automatic noCall(input int c);
      logic hit;
      hit = 1'b0;
      repeat (c) begin
         @(negedge sys_clk);
         if (vecCall !== 1'b0) hit = 1'b1;
      end
      chk("nocall", {31'h0, hit}, 32'h0);
      @(posedge sys_clk);
   endtask : noCall

   task automatic ret(input logic [1:0] x);
      int k;
      k = 0;
      retiNext <= 1'b1;
      @(posedge sys_clk);
      retiNext <= 1'b0;
      do begin
         @(negedge sys_clk);
         k++;
      end while (!(instrDone === 1'b1 && instrReti === 1'b1) && k < 20);
      if (instrDone !== 1'b1 || instrReti !== 1'b1) begin
         fails++;
         conclude();
      end
      @(negedge sys_clk);
      chk("svc", {30'h0, inService}, {30'h0, x});
      @(posedge sys_clk);
   endtask : ret

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   initial begin
      {reset_n, wbCyc, wbStb, wbWe, run, multi, retiNext} = 7'h00;
      {wbAdr, wbSel, wbDat, srcEvent} = '0;
      fails = 0;
      total_checks = 0;
      rows = '{'{12'h001, 12'h000, 16'h0003, 12'h000},
         '{12'h002, 12'h000, 16'h000B, 12'h000},
         '{12'h004, 12'h000, 16'h0013, 12'h000},
         '{12'h008, 12'h008, 16'h001B, 12'h000},
         '{12'h010, 12'h000, 16'h0023, 12'h010},
         '{12'h020, 12'h000, 16'h002B, 12'h020},
         '{12'h040, 12'h000, 16'h0033, 12'h040},
         '{12'h080, 12'h000, 16'h003B, 12'h080},
         '{12'h100, 12'h000, 16'h0043, 12'h100},
         '{12'h200, 12'h000, 16'h004B, 12'h200},
         '{12'h400, 12'h000, 16'h0053, 12'h400},
         '{12'h800, 12'h000, 16'h005B, 12'h800},
         '{12'h024, 12'h020, 16'h002B, 12'h024},
         '{12'h280, 12'h000, 16'h003B, 12'h280}};
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      // 0x18 is unmapped and must read zero
      for (n = 0; n < 7; n++) rdchk(5'(4 * n), 32'h0);
      wb(1'b1, vih_pkg::OffIrqEnable, 32'h80, 4'hE);
      rdchk(vih_pkg::OffIrqEnable, 32'h0);
      run <= 1'b1;
      wr(vih_pkg::OffExtEnable, 32'h04);
      evt(12'h100);
      noCall(20);
      rdchk(vih_pkg::OffPending, 32'h100);
      wr(vih_pkg::OffExtEnable, 32'h0);
      wr(vih_pkg::OffIrqEnable, 32'h80);
      noCall(20);
      wr(vih_pkg::OffExtEnable, 32'h04);
      waitCall(16'h0043);
      wr(vih_pkg::OffPending, 32'h0);
      ret(2'b00);
      wr(vih_pkg::OffExtEnable, 32'h10);
      wr(vih_pkg::OffPending, 32'h400);
      waitCall(16'h0053);
      ret(2'b00);
      n = 0;
      for (int k = 0; k < 40 && vecCall !== 1'b1; k++) begin
         @(negedge sys_clk);
         if (instrDone === 1'b1) n++;
      end
      if (vecCall !== 1'b1) begin
         fails++;
         conclude();
      end
      chk("reentry", n, 1);
      chk("vec", {16'h0, vecAddr}, 32'h53);
      @(posedge sys_clk);
      wr(vih_pkg::OffPending, 32'h0);
      ret(2'b00);
      foreach (rows[i]) begin
         run <= 1'b0;
         wr(vih_pkg::OffIrqEnable, 32'hBF);
         wr(vih_pkg::OffExtEnable, 32'h3F);
         wr(vih_pkg::OffPrioSel, {26'h0, rows[i].prio[5:0]});
         wr(vih_pkg::OffExtPrioSel, {26'h0, rows[i].prio[11:6]});
         evt(rows[i].evt);
         run <= 1'b1;
         waitCall(rows[i].vec);
         e = (rows[i].prio & rows[i].evt) != 12'h0 ? 2'b10 : 2'b01;
         chk("svc", {30'h0, inService}, {30'h0, e});
         rdchk(vih_pkg::OffPending, {20'h0, rows[i].pend});
         wr(vih_pkg::OffPending, 32'h0);
         ret(2'b00);
      end
      wr(vih_pkg::OffPrioSel, 32'h20);
      evt(12'h010);
      waitCall(16'h0023);
      evt(12'h020);
      waitCall(16'h002B);
      chk("svc", {30'h0, inService}, 32'h3);
      evt(12'h001);
      noCall(20);
      wr(vih_pkg::OffPending, 32'h011);
      ret(2'b01);
      noCall(20);
      wr(vih_pkg::OffPending, 32'h0);
      ret(2'b00);
      run <= 1'b0;
      multi <= 1'b1;
      wr(vih_pkg::OffIrqEnable, 32'h3F);
      evt(12'h002);
      run <= 1'b1;
      noCall(20);
      run <= 1'b0;
      multi <= 1'b0;
      wr(vih_pkg::OffIrqEnable, 32'hBF);
      wr(vih_pkg::OffIrqEnable, 32'h3F);
      run <= 1'b1;
      waitCall(16'h000B);
      rdchk(vih_pkg::OffIrqEnable, 32'h3F);
      ret(2'b00);
      conclude();
   end
endmodule : vectored_interrupt_handler_tb_top
`default_nettype wire
